/* osps_pkg.sv */
// constants, types and register map of the fuse programming and verification block
// assumes a 100 MHz single clock and a classic Wishbone register bus
//
// Overview of operation
// - signature starts at zero, takes twenty-eight byte updates, final byte is result
// - each update: shift left, xor byte, keep 8 bits, xor 29 if old bit7 set
// - after power-up the part enters communication mode when the lock bit is zero
// - writing 0x20 to 0x23 resets the signal core; done before first angle read
// - burn starts after matching readback by 0x70 to 0x62 then 0x51 to 0x63
// - burn completes 10 ms after trigger; programmer waits that long
// - writing 0x40 to 0x23 selects the guard-band read threshold
// - writing 0x00 to 0x23 selects normal threshold for the second pass
// - shadow registers reload from fuses within 5 ms after threshold write
// - after reset with lock programmed the part starts in functional mode
package osps_pkg;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int BURN_TIME_US    = 10000;
  localparam int REFRESH_TIME_US = 5000;
  localparam int BURN_CYCLES     = BURN_TIME_US * CLK_MHZ;
  localparam int REFRESH_CYCLES  = REFRESH_TIME_US * CLK_MHZ;
  localparam int TIMER_W         = 20;

  // ---------------------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_SIG    = 8'h1E;
  localparam logic [7:0] IDX_THRESH = 8'h23;
  localparam logic [7:0] IDX_KEY1   = 8'h62;
  localparam logic [7:0] IDX_KEY2   = 8'h63;
  localparam logic [7:0] IDX_ANGLE  = 8'h70;
  localparam logic [7:0] IDX_STATUS = 8'h7F;
  localparam int         SHADOW_N   = 31;

  // ---------------------------------------------------------------------------
  // signature and commands
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SIG_FIRST     = 8'h02;
  localparam logic [7:0] SIG_LAST      = 8'h1D;
  localparam int         SIG_STEPS     = 28;
  localparam logic [7:0] MISR_POLY     = 8'h1D;
  localparam logic [7:0] MISR_RESET    = 8'h00;
  localparam logic [7:0] KEY1_VAL      = 8'h70;
  localparam logic [7:0] KEY2_VAL      = 8'h51;
  localparam logic [7:0] CMD_DSP_RESET = 8'h20;
  localparam logic [7:0] CMD_GUARD     = 8'h40;
  localparam logic [7:0] CMD_NORMAL    = 8'h00;
  localparam logic [7:0] LOCK_IDX      = 8'h1D;
  localparam int         LOCK_BIT      = 7;
  localparam int         ANGLE_W       = 14;

  // ---------------------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------------------
  localparam int ST_B_BUSY  = 0;
  localparam int ST_B_COMM  = 1;
  localparam int ST_B_GUARD = 2;
  localparam int ST_B_SIGOK = 3;
  localparam int ST_B_SIGER = 4;
  localparam int ST_B_ARMED = 5;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BURN,
    ST_WAIT,
    ST_LOAD,
    ST_SIG,
    ST_CHECK
  } osps_state_t;
endpackage

/* osps_misr_if.sv */
// signals between the sequencer and the signature engine
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface osps_misr_if;
  logic       clr;
  logic       step;
  logic [7:0] data;
  logic [7:0] sig;
  modport ctrl   (output clr, output step, output data, input sig);
  modport engine (input clr, input step, input data, output sig);
endinterface
`default_nettype wire

/* osps_misr.sv */
// multiple-input signature register over the fuse image bytes
// assumes one byte per step on the sequencer clock
`timescale 1ns/1ps
`default_nettype none
module osps_misr (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  osps_misr_if.engine m
);
  import osps_pkg::*;

  logic [7:0] sig_reg;
  logic [7:0] sig_next;

  always_comb begin
    sig_next = {sig_reg[6:0], 1'b0} ^ m.data;
    if (sig_reg[7]) begin
      sig_next = sig_next ^ MISR_POLY;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || m.clr) begin
      sig_reg <= MISR_RESET;
    end else if (m.step) begin
      sig_reg <= sig_next;
    end
  end

  assign m.sig = sig_reg;

  a_misr_update: assert property (@(posedge clk_i) disable iff (rst_i)
    (m.step && !m.clr) |=> m.sig == ((({$past(m.sig[6:0]), 1'b0} ^ $past(m.data))
      ^ ($past(m.sig[7]) ? 8'h1D : 8'h00)))) else $error("signature update wrong");
  a_misr_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    m.clr |=> m.sig == 8'h00) else $error("signature not cleared to zero");
endmodule
`default_nettype wire

/* osps_top.sv */
// fuse image, shadow registers, burn and refresh sequencer behind a Wishbone slave
// assumes a classic Wishbone master on clk_i; angle_i comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module osps_top #(
  parameter int BURN_CYC    = osps_pkg::BURN_CYCLES,
  parameter int REFRESH_CYC = osps_pkg::REFRESH_CYCLES
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         fuse_blank_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [9:0]                   adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  input  wire logic [osps_pkg::ANGLE_W-1:0] angle_i,
  output logic                              comm_mode_o,
  output logic                              dsp_reset_o,
  output logic                              guard_sel_o,
  output logic                              sig_err_o,
  output logic                              busy_o
);
  import osps_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  // a zero count would wrap the timer to its maximum, a large one overflows the timer
  if (BURN_CYC < 1 || BURN_CYC >= (1 << TIMER_W)) begin
    $error("burn count out of range");
  end
  if (REFRESH_CYC < 1 || REFRESH_CYC >= (1 << TIMER_W)) begin
    $error("refresh count out of range");
  end

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic [7:0]         idx;
  logic               req;
  logic               wr;
  logic [7:0]         wbyte;
  logic               ack_reg;
  logic [31:0]        dat_reg;
  logic [31:0]        rd_word;
  osps_state_t        state_reg;
  logic [TIMER_W-1:0] timer_reg;
  logic [7:0]         shadow_reg [SHADOW_N];
  logic [7:0]         fuse_reg   [SHADOW_N];
  logic [7:0]         sig_idx_reg;
  logic               boot_reg;
  logic               comm_reg;
  logic               guard_reg;
  logic               armed_reg;
  logic               dsp_rst_reg;
  logic               sig_ok_reg;
  logic               sig_err_reg;
  logic               idle;
  logic               wr_cfg;

  osps_misr_if misr_bus ();

  osps_misr u_misr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .m     (misr_bus.engine)
  );

  assign idx   = adr_i[9:2];
  assign req   = cyc_i && stb_i && !ack_reg;
  assign wr    = req && we_i && sel_i[0];
  assign wbyte = dat_i[7:0];
  assign idle  = (state_reg == ST_IDLE);
  // configuration writes only in communication mode and never during burn or refresh
  assign wr_cfg = wr && comm_reg && idle;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (idx < 8'(SHADOW_N)) begin
      rd_word[7:0] = shadow_reg[idx[4:0]];
    end else if (idx == IDX_THRESH) begin
      rd_word[7:0] = guard_reg ? CMD_GUARD : CMD_NORMAL;
    end else if (idx == IDX_ANGLE) begin
      rd_word[ANGLE_W-1:0] = angle_i;
    end else if (idx == IDX_STATUS) begin
      rd_word[ST_B_BUSY]  = !idle;
      rd_word[ST_B_COMM]  = comm_reg;
      rd_word[ST_B_GUARD] = guard_reg;
      rd_word[ST_B_SIGOK] = sig_ok_reg;
      rd_word[ST_B_SIGER] = sig_err_reg;
      rd_word[ST_B_ARMED] = armed_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_reg <= rd_word;
    end
  end

  // ---------------------------------------------------------------------------
  // command register: core reset and read threshold
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dsp_rst_reg <= 1'b0;
    end else begin
      dsp_rst_reg <= wr && idx == IDX_THRESH && wbyte == CMD_DSP_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      guard_reg <= 1'b0;
    end else if (wr_cfg && idx == IDX_THRESH) begin
      if (wbyte == CMD_GUARD) begin
        guard_reg <= 1'b1;
      end else if (wbyte == CMD_NORMAL) begin
        guard_reg <= 1'b0;
      end
    end
  end

  // two-byte key: any other write between the halves disarms it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_reg <= 1'b0;
    end else if (wr_cfg) begin
      armed_reg <= (idx == IDX_KEY1) && (wbyte == KEY1_VAL);
    end
  end

  // ---------------------------------------------------------------------------
  // sequencer: burn, refresh wait, reload, signature check
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_LOAD;
      timer_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (wr_cfg && idx == IDX_KEY2 && wbyte == KEY2_VAL && armed_reg) begin
            state_reg <= ST_BURN;
            timer_reg <= TIMER_W'(BURN_CYC - 1);
          end else if (wr_cfg && idx == IDX_THRESH && (wbyte == CMD_GUARD || wbyte == CMD_NORMAL)) begin
            state_reg <= ST_WAIT;
            timer_reg <= TIMER_W'(REFRESH_CYC - 1);
          end
        end
        ST_BURN: begin
          if (timer_reg == '0) begin
            state_reg <= ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        ST_WAIT: begin
          if (timer_reg == '0) begin
            state_reg <= ST_LOAD;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        ST_LOAD: begin
          state_reg <= ST_SIG;
        end
        ST_SIG: begin
          if (sig_idx_reg == SIG_LAST) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg == ST_LOAD) begin
      sig_idx_reg <= SIG_FIRST;
    end else if (state_reg == ST_SIG) begin
      sig_idx_reg <= sig_idx_reg + 8'h01;
    end
  end

  assign misr_bus.clr  = (state_reg == ST_LOAD);
  assign misr_bus.step = (state_reg == ST_SIG);
  assign misr_bus.data = shadow_reg[sig_idx_reg[4:0]];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sig_ok_reg  <= 1'b0;
      sig_err_reg <= 1'b0;
    end else if (state_reg == ST_CHECK) begin
      sig_ok_reg <= (misr_bus.sig == shadow_reg[IDX_SIG[4:0]]);
      // a signature fault holds until the next reset
      if (misr_bus.sig != shadow_reg[IDX_SIG[4:0]]) begin
        sig_err_reg <= 1'b1;
      end
    end
  end

  // mode is fixed once per power-up, from the lock bit as just reloaded
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_reg <= 1'b1;
      comm_reg <= 1'b0;
    end else if (boot_reg && state_reg == ST_CHECK) begin
      boot_reg <= 1'b0;
      comm_reg <= !shadow_reg[LOCK_IDX[4:0]][LOCK_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // shadow image and fuse array
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < SHADOW_N; i++) begin
        shadow_reg[i] <= 8'h00;
      end
    end else if (state_reg == ST_LOAD) begin
      for (int i = 0; i < SHADOW_N; i++) begin
        shadow_reg[i] <= fuse_reg[i];
      end
    end else if (wr_cfg && idx < 8'(SHADOW_N)) begin
      shadow_reg[idx[4:0]] <= wbyte;
    end
  end

  // fuses keep their content over rst_i; only a blank part starts at zero
  always_ff @(posedge clk_i) begin
    if (fuse_blank_i) begin
      for (int i = 0; i < SHADOW_N; i++) begin
        fuse_reg[i] <= 8'h00;
      end
    end else if (state_reg == ST_BURN && timer_reg == '0) begin
      for (int i = 0; i < SHADOW_N; i++) begin
        fuse_reg[i] <= fuse_reg[i] | shadow_reg[i];
      end
    end
  end

  assign dat_o       = dat_reg;
  assign ack_o       = ack_reg;
  assign comm_mode_o = comm_reg;
  assign dsp_reset_o = dsp_rst_reg;
  assign guard_sel_o = guard_reg;
  assign sig_err_o   = sig_err_reg;
  assign busy_o      = !idle;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_core_reset: assert property (
    wr && idx == IDX_THRESH && wbyte == 8'h20 |=> dsp_reset_o ##1 !dsp_reset_o)
    else $error("core reset pulse missing");
  a_burn_key: assert property (
    $rose(state_reg == ST_BURN) |-> $past(armed_reg) && $past(comm_reg))
    else $error("burn without key");
  a_burn_hold: assert property (
    state_reg == ST_BURN && timer_reg != '0 |=> state_reg == ST_BURN)
    else $error("burn ended early");
  a_burn_end: assert property (
    state_reg == ST_BURN && timer_reg == '0 |=> state_reg == ST_IDLE)
    else $error("burn did not end on time");
  a_locked_burn: assert property (
    wr && !comm_reg && idx == IDX_KEY2 |=> state_reg != ST_BURN)
    else $error("burn started outside communication mode");
  a_guard_sel: assert property (
    wr_cfg && idx == IDX_THRESH && wbyte == 8'h40 |=> guard_sel_o && state_reg == ST_WAIT)
    else $error("guard threshold not taken");
  a_normal_sel: assert property (
    wr_cfg && idx == IDX_THRESH && wbyte == 8'h00 |=> !guard_sel_o && state_reg == ST_WAIT)
    else $error("normal threshold not taken");
  a_refresh_wait: assert property (
    $rose(state_reg == ST_WAIT) |-> timer_reg == TIMER_W'(REFRESH_CYC - 1))
    else $error("refresh wait wrong length");
  a_refresh_load: assert property (
    state_reg == ST_WAIT && timer_reg == '0 |=> state_reg == ST_LOAD)
    else $error("reload not started after refresh wait");
  a_reload_image: assert property (
    state_reg == ST_LOAD |=> shadow_reg[IDX_SIG[4:0]] == $past(fuse_reg[IDX_SIG[4:0]])
      && shadow_reg[LOCK_IDX[4:0]] == $past(fuse_reg[LOCK_IDX[4:0]]))
    else $error("shadow not reloaded from fuses");
  a_sig_steps: assert property (
    $rose(state_reg == ST_SIG) |-> (state_reg == ST_SIG) [*8] ##21 state_reg == ST_CHECK)
    else $error("signature step count wrong");
  a_boot_mode: assert property (
    boot_reg && state_reg == ST_CHECK |=> comm_mode_o == !$past(shadow_reg[29][7]))
    else $error("mode after power-up wrong");
endmodule
`default_nettype wire

/* osps_prog_model.sv */
// programmer model: classic Wishbone master plus signature arithmetic
// assumes a slave on clk_i that answers with a registered ack
`timescale 1ns/1ps
`default_nettype none
module osps_prog_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [9:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  output logic             hung_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 10'h000;
    sel_o = 4'hF;
    dat_o = 32'h00000000;
    hung_o = 1'b0;
  end
  // ---------------------------------------------------------------------------
  // one bus cycle, held until ack is seen at a rising edge
  // ---------------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] v, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {idx, 2'b00};
    dat_o <= {24'h000000, v};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 64);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // released data lines must not keep looking valid
    dat_o <= ~{24'h000000, v};
    if (n >= 64) hung_o <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] q;
    xfer(1'b1, idx, v, q);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] q);
    xfer(1'b0, idx, 8'h00, q);
  endtask
  // ---------------------------------------------------------------------------
  // signature over bytes 0x02..0x1D, ascending
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] sign(input logic [7:0] b [0:31]);
    logic [7:0] m;
    logic [7:0] old;
    m = 8'h00;
    for (int i = 2; i <= 29; i++) begin
      old = m;
      m = (m << 1) ^ b[i];
      if (old[7]) m = m ^ 8'h1D;
    end
    return m;
  endfunction
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench: programming, burn and two-pass verification flow
// assumes the programmer model drives the bus; short burn and refresh counts
`timescale 1ns/1ps
`default_nettype none
module tb;
  import osps_pkg::*;
  localparam int BURN = 50;
  localparam int REFR = 40;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                fuse_blank_i = 1'b1;
  logic [ANGLE_W-1:0]  angle_i = 14'h2A5C;
  wire logic           cyc, stb, we, ack, hung;
  wire logic [9:0]     adr;
  wire logic [3:0]     sel;
  wire logic [31:0]    dat_w, dat_r;
  wire logic           comm_mode_o, dsp_reset_o, guard_sel_o, sig_err_o, busy_o;
  int                  n_fail = 0;
  int                  checks_done = 0;
  int                  n_dsp = 0;
  int                  cnt;
  logic [7:0]          img [0:31];
  logic [7:0]          rb [0:31];
  logic [7:0]          sig;
  logic [31:0]         q;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (dsp_reset_o === 1'b1) n_dsp <= n_dsp + 1;

  osps_top #(.BURN_CYC(BURN), .REFRESH_CYC(REFR)) osps_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .fuse_blank_i(fuse_blank_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .angle_i(angle_i), .comm_mode_o(comm_mode_o), .dsp_reset_o(dsp_reset_o),
    .guard_sel_o(guard_sel_o), .sig_err_o(sig_err_o), .busy_o(busy_o));
  osps_prog_model osps_prog_model_inst (
    .clk_i(clk_i), .ack_i(ack), .dat_i(dat_r), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(dat_w), .hung_o(hung));

  // ---------------------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge hung) begin
    n_fail++;
    complete_run();
  end
  task automatic wait_idle(output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (busy_o === 1'b1 && c < 2000);
    if (c >= 2000) begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic write_range(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) osps_prog_model_inst.wr(i[7:0], img[i]);
  endtask
  task automatic check_range(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      osps_prog_model_inst.rd(i[7:0], q);
      check(q, {24'h000000, img[i]});
    end
  endtask
  // clear signature, pick threshold, let the reload land, compare
  task automatic verify(input logic [7:0] thr, input logic g);
    osps_prog_model_inst.wr(IDX_SIG, 8'h00);
    osps_prog_model_inst.wr(IDX_THRESH, thr);
    wait_idle(cnt);
    check(guard_sel_o, g);
    osps_prog_model_inst.rd(IDX_SIG, q);
    check(q, {24'h000000, sig});
    check_range(8'h0A, 8'h1E);
    check(sig_err_o, 1'b0);
    osps_prog_model_inst.rd(IDX_THRESH, q);
    check(q, {24'h000000, thr});
    osps_prog_model_inst.rd(IDX_STATUS, q);
    check(q[ST_B_SIGOK], 1'b1);
    check(q[ST_B_GUARD], g);
    if (n_fail != 0) complete_run(); // a failed pass is final, no second burn
    $display("verify pass %h done", thr);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    fuse_blank_i <= 1'b0;
    wait_idle(cnt);
    check(comm_mode_o, 1'b1);
    osps_prog_model_inst.rd(IDX_STATUS, q);
    check(q[ST_B_COMM], 1'b1);
    $display("boot done");
    osps_prog_model_inst.wr(IDX_THRESH, CMD_DSP_RESET);
    repeat (2) @(posedge clk_i);
    check(n_dsp, 1);
    check(busy_o, 1'b0);
    osps_prog_model_inst.rd(IDX_ANGLE, q);
    check(q, {18'h00000, angle_i});
    osps_prog_model_inst.rd(8'h50, q);
    check(q, 32'h00000000);
    $display("core reset and angle done");
    for (int i = 0; i < 32; i++) img[i] = (i < 10) ? 8'h00 : 8'(i * 11 + 53);
    write_range(8'h0A, 8'h1E);
    check_range(8'h0A, 8'h1E);
    img[LOCK_IDX] = img[LOCK_IDX] | 8'h80;
    write_range(8'h0A, 8'h1D);
    for (int i = 0; i <= 29; i++) begin
      osps_prog_model_inst.rd(i[7:0], q);
      rb[i] = q[7:0];
    end
    sig = osps_prog_model_inst.sign(rb);
    osps_prog_model_inst.wr(IDX_SIG, sig);
    img[IDX_SIG] = sig;
    check_range(8'h0A, 8'h1E);
    if (n_fail != 0) complete_run(); // abort before burning on bad readback
    $display("image done");
    osps_prog_model_inst.wr(IDX_KEY1, KEY1_VAL);
    osps_prog_model_inst.rd(IDX_STATUS, q);
    check(q[ST_B_ARMED], 1'b1);
    osps_prog_model_inst.wr(8'h50, 8'h00);
    osps_prog_model_inst.rd(IDX_STATUS, q);
    check(q[ST_B_ARMED], 1'b0);
    osps_prog_model_inst.wr(IDX_KEY2, KEY2_VAL);
    @(posedge clk_i);
    check(busy_o, 1'b0);
    osps_prog_model_inst.wr(IDX_KEY1, KEY1_VAL);
    osps_prog_model_inst.wr(IDX_KEY2, KEY2_VAL);
    wait_idle(cnt);
    check(cnt >= BURN, 1'b1);
    $display("burn done");
    verify(CMD_GUARD, 1'b1);
    verify(CMD_NORMAL, 1'b0);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_idle(cnt);
    check(comm_mode_o, 1'b0);
    osps_prog_model_inst.wr(8'h0A, ~img[10]);
    osps_prog_model_inst.rd(8'h0A, q);
    check(q, {24'h000000, img[10]});
    check(sig_err_o, 1'b0);
    osps_prog_model_inst.wr(IDX_KEY1, KEY1_VAL);
    osps_prog_model_inst.wr(IDX_KEY2, KEY2_VAL);
    @(posedge clk_i);
    check(busy_o, 1'b0);
    $display("locked restart done");
    complete_run();
  end
endmodule
`default_nettype wire
